/* File: hw/rieu_pkg.sv */
// Constants and state types of the reset and interrupt exception unit
package rieu_pkg;

    localparam int NUM_EXT = 8;
    localparam int NUM_INT = 33;
    localparam int NUM_SRC = 1 + NUM_EXT + NUM_INT;
    localparam int IDX_W = 6;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int VADDR_W = 16;
    localparam int CNT_W = 10;

    // Source index in the arbiter request word
    localparam int IDX_NMI = 0;
    localparam int IDX_EXT0 = 1;
    localparam int IDX_INT0 = 9;
    localparam int IDX_WDT_OVF = 41;

    // Vector numbers
    localparam logic [5:0] VEC_RESET = 6'h00;
    localparam logic [5:0] VEC_NMI = 6'h03;
    localparam logic [5:0] VEC_EXT0 = 6'h04;
    localparam logic [5:0] VEC_INT0 = 6'h0C;
    localparam logic [5:0] VEC_WDT_OVF = 6'h2C;

    // Timing in system clock cycles
    localparam logic [CNT_W-1:0] WDT_PULSE_CYCLES = 10'h206;
    localparam logic [CNT_W-1:0] MIN_CLEAR_CYCLES = 10'h00A;

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_SENSE = 4'h1;
    localparam logic [ADDR_W-1:0] REG_ENABLE = 4'h2;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PEND = 4'h4;

    // Control register fields
    localparam int CTRL_EDGE_BIT = 0;
    localparam int CTRL_WDT_NMI_BIT = 1;
    localparam int CTRL_WDT_RST_BIT = 2;

    // Status register fields
    localparam int STAT_SRC_EXT_BIT = 0;
    localparam int STAT_BLOCK_BIT = 1;
    localparam int STAT_NMI_PEND_BIT = 2;
    localparam int STAT_WDT_PEND_BIT = 3;

    // Reset values
    localparam logic [DATA_W-1:0] SENSE_RST = 8'h00;
    localparam logic [DATA_W-1:0] ENABLE_RST = 8'h00;

    typedef enum logic [1:0] {
        MODE_RESET,
        MODE_WDT_PULSE,
        MODE_RUN
    } rieu_mode_t;

    typedef struct packed {
        logic clr_s1;
        logic clr_s2;
        logic nmi_s1;
        logic nmi_s2;
        logic nmi_prev;
        logic [NUM_EXT-1:0] ext_s1;
        logic [NUM_EXT-1:0] ext_s2;
        logic [NUM_EXT-1:0] ext_prev;
        rieu_mode_t mode;
        logic [CNT_W-1:0] wdt_cnt;
        logic src_ext;
        logic block;
        logic nmi_pend;
        logic wdt_pend;
        logic [NUM_EXT-1:0] ext_pend;
        logic edge_sel;
        logic wdt_to_nmi;
        logic wdt_rst_sel;
        logic [NUM_EXT-1:0] sense;
        logic [NUM_EXT-1:0] enable;
        logic take;
        logic mask_set;
        logic [5:0] vec_num;
        logic [VADDR_W-1:0] vec_addr;
        logic [DATA_W-1:0] rdata;
    } rieu_state_t;

endpackage

/* File: hw/rieu_prio_enc.sv */
// Fixed priority encoder: lowest set index wins
`timescale 1ns/10ps
`default_nettype none
module rieu_prio_enc #(
    parameter int N = 42,
    parameter int W = 6
) (
    // Requests
    input wire logic [N-1:0] req,
    // Winner
    output logic found,
    output logic [W-1:0] idx
);
    always_comb begin
        found = 1'b0;
        idx = '0;
        // Scan downward so the lowest index is written last
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule // rieu_prio_enc
`default_nettype wire

/* File: hw/rieu_top.sv */
// Reset and interrupt exception unit of the microcontroller core
`timescale 1ns/10ps
`default_nettype none
module rieu_top #(
    parameter logic [rieu_pkg::CNT_W-1:0] WDT_PULSE = rieu_pkg::WDT_PULSE_CYCLES
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    // Pins
    input wire logic chip_clear_n,
    input wire logic unmaskable_pin,
    input wire logic [rieu_pkg::NUM_EXT-1:0] ext_line_requests,
    // Peripheral and watchdog events
    input wire logic [rieu_pkg::NUM_INT-1:0] periph_req,
    input wire logic wdt_overflow_event,
    // CPU core
    input wire logic instr_end,
    input wire logic seq_end,
    input wire logic cc_and_instr,
    input wire logic cc_or_instr,
    input wire logic cc_xor_instr,
    input wire logic cc_load_instr,
    input wire logic cond_code_mask,
    output logic chip_in_reset,
    output logic exc_take,
    output logic mask_set,
    output logic [5:0] vec_num,
    output logic [rieu_pkg::VADDR_W-1:0] vec_addr,
    // Register port
    input wire logic [rieu_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rieu_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rieu_pkg::DATA_W-1:0] reg_rdata
);
    localparam int NE = rieu_pkg::NUM_EXT;
    localparam int NS = rieu_pkg::NUM_SRC;
    localparam int IW = rieu_pkg::IDX_W;

    // Pins idle high so no false edge appears after reset
    localparam rieu_pkg::rieu_state_t ST_RST = '{
        clr_s1: 1'b0,
        clr_s2: 1'b0,
        nmi_s1: 1'b1,
        nmi_s2: 1'b1,
        nmi_prev: 1'b1,
        ext_s1: '1,
        ext_s2: '1,
        ext_prev: '1,
        mode: rieu_pkg::MODE_RESET,
        wdt_cnt: '0,
        src_ext: 1'b1,
        block: 1'b1,
        nmi_pend: 1'b0,
        wdt_pend: 1'b0,
        ext_pend: '0,
        edge_sel: 1'b0,
        wdt_to_nmi: 1'b0,
        wdt_rst_sel: 1'b0,
        sense: rieu_pkg::SENSE_RST,
        enable: rieu_pkg::ENABLE_RST,
        take: 1'b0,
        mask_set: 1'b0,
        vec_num: rieu_pkg::VEC_RESET,
        vec_addr: '0,
        rdata: '0
    };

    rieu_pkg::rieu_state_t st;
    rieu_pkg::rieu_state_t next_st;

    logic running;
    logic cc_any;
    logic accept_point;
    logic fire;
    logic win_valid;
    logic [IW-1:0] win_idx;
    logic nmi_edge;
    logic nmi_take;
    logic wdt_take;
    logic [rieu_pkg::NUM_INT-1:0] int_req;
    logic [NE-1:0] line_req;
    logic [NE-1:0] line_pend_nx;
    logic [NS-1:0] req_raw;
    logic [NS-1:0] req;

    assign running = (st.mode == rieu_pkg::MODE_RUN);
    assign cc_any = cc_and_instr | cc_or_instr | cc_xor_instr | cc_load_instr;
    // No boundary right after a condition-code instruction, nor at the
    // end of the reset sequence before the first instruction has run
    assign accept_point = (instr_end & ~cc_any) | (seq_end & ~st.block);
    assign fire = running & accept_point & win_valid;

    // Unmaskable input: one edge only, polarity chosen by software
    assign nmi_edge = st.edge_sel ? (~st.nmi_prev & st.nmi_s2) : (st.nmi_prev & ~st.nmi_s2);
    assign nmi_take = fire & (win_idx == IW'(rieu_pkg::IDX_NMI));
    assign wdt_take = fire & (win_idx == IW'(rieu_pkg::IDX_WDT_OVF));

    // Watchdog overflow as a maskable source shares the last peripheral slot
    assign int_req = {periph_req[rieu_pkg::NUM_INT-1] | st.wdt_pend,
                      periph_req[rieu_pkg::NUM_INT-2:0]};

    for (genvar g = 0; g < NE; g++) begin : g_line
        logic fall;
        logic take_line;
        logic drop;
        assign fall = st.ext_prev[g] & ~st.ext_s2[g];
        // Level mode asks while low and enabled; edge mode keeps a latch
        assign line_req[g] = st.sense[g] ? st.ext_pend[g] : (~st.ext_s2[g] & st.enable[g]);
        assign take_line = fire & (win_idx == IW'(rieu_pkg::IDX_EXT0 + g));
        // A latched edge survives disabling until masked, level and disabled
        assign drop = cond_code_mask & ~st.sense[g] & ~st.enable[g];
        // A new edge in the clearing cycle wins over the clear
        assign line_pend_nx[g] = (st.sense[g] & st.enable[g] & fall) |
                                 (st.ext_pend[g] & ~take_line & ~drop);
    end

    assign req_raw = {int_req, line_req, st.nmi_pend};
    // The mask flag refuses everything but the unmaskable source
    assign req = {req_raw[NS-1:1] & {(NS-1){~cond_code_mask}}, req_raw[0]};

    rieu_prio_enc #(
        .N(NS),
        .W(IW)
    ) u_prio (
        .req(req),
        .found(win_valid),
        .idx(win_idx)
    );

    always_comb begin
        next_st = st;
        next_st.take = 1'b0;
        next_st.mask_set = 1'b0;
        next_st.rdata = '0;

        // Pin synchronisers
        next_st.clr_s1 = chip_clear_n;
        next_st.clr_s2 = st.clr_s1;
        next_st.nmi_s1 = unmaskable_pin;
        next_st.nmi_s2 = st.nmi_s1;
        next_st.nmi_prev = st.nmi_s2;
        next_st.ext_s1 = ext_line_requests;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_prev = st.ext_s2;

        // Pending sources; a new event beats its own clear
        next_st.nmi_pend = nmi_edge |
                           (wdt_overflow_event & ~st.wdt_rst_sel & st.wdt_to_nmi) |
                           (st.nmi_pend & ~nmi_take);
        next_st.wdt_pend = (wdt_overflow_event & ~st.wdt_rst_sel & ~st.wdt_to_nmi) |
                           (st.wdt_pend & ~wdt_take);
        next_st.ext_pend = line_pend_nx;

        // Boundary blocking
        if (instr_end) begin
            next_st.block = cc_any;
        end

        // Register writes
        if (reg_wr && running) begin
            case (reg_addr)
                rieu_pkg::REG_CTRL: begin
                    next_st.edge_sel = reg_wdata[rieu_pkg::CTRL_EDGE_BIT];
                    next_st.wdt_to_nmi = reg_wdata[rieu_pkg::CTRL_WDT_NMI_BIT];
                    next_st.wdt_rst_sel = reg_wdata[rieu_pkg::CTRL_WDT_RST_BIT];
                end
                rieu_pkg::REG_SENSE: next_st.sense = reg_wdata;
                rieu_pkg::REG_ENABLE: next_st.enable = reg_wdata;
                default: ;
            endcase
        end

        // Register reads, data in the following cycle
        if (reg_rd) begin
            case (reg_addr)
                rieu_pkg::REG_CTRL: begin
                    next_st.rdata[rieu_pkg::CTRL_EDGE_BIT] = st.edge_sel;
                    next_st.rdata[rieu_pkg::CTRL_WDT_NMI_BIT] = st.wdt_to_nmi;
                    next_st.rdata[rieu_pkg::CTRL_WDT_RST_BIT] = st.wdt_rst_sel;
                end
                rieu_pkg::REG_SENSE: next_st.rdata = st.sense;
                rieu_pkg::REG_ENABLE: next_st.rdata = st.enable;
                rieu_pkg::REG_STATUS: begin
                    next_st.rdata[rieu_pkg::STAT_SRC_EXT_BIT] = st.src_ext;
                    next_st.rdata[rieu_pkg::STAT_BLOCK_BIT] = st.block;
                    next_st.rdata[rieu_pkg::STAT_NMI_PEND_BIT] = st.nmi_pend;
                    next_st.rdata[rieu_pkg::STAT_WDT_PEND_BIT] = st.wdt_pend;
                end
                rieu_pkg::REG_PEND: next_st.rdata = st.ext_pend;
                default: next_st.rdata = '0;
            endcase
        end

        // Interrupt acceptance sets the mask and hands out the vector
        if (fire) begin
            next_st.take = 1'b1;
            next_st.mask_set = 1'b1;
            next_st.vec_num = win_idx + rieu_pkg::VEC_NMI;
            next_st.vec_addr = {9'h000, win_idx + rieu_pkg::VEC_NMI, 1'b0};
        end

        // Pending flags, edge select, sense, enable and block are held initialised while in reset; wdt_to_nmi and wdt_rst_sel keep their values
        if (!running) begin
            next_st.nmi_pend = 1'b0;
            next_st.wdt_pend = 1'b0;
            next_st.ext_pend = '0;
            next_st.edge_sel = 1'b0;
            next_st.sense = rieu_pkg::SENSE_RST;
            next_st.enable = rieu_pkg::ENABLE_RST;
            next_st.block = 1'b1;
        end

        case (st.mode)
            rieu_pkg::MODE_RUN: begin
                if (wdt_overflow_event && st.wdt_rst_sel) begin
                    next_st.mode = rieu_pkg::MODE_WDT_PULSE;
                    next_st.wdt_cnt = WDT_PULSE - 10'h001;
                    next_st.src_ext = 1'b0;
                    next_st.take = 1'b0;
                    next_st.mask_set = 1'b0;
                end
            end
            rieu_pkg::MODE_WDT_PULSE: begin
                if (st.wdt_cnt == '0) begin
                    next_st.mode = rieu_pkg::MODE_RUN;
                end else begin
                    next_st.wdt_cnt = st.wdt_cnt - 10'h001;
                end
            end
            rieu_pkg::MODE_RESET: begin
                if (st.clr_s2) begin
                    next_st.mode = rieu_pkg::MODE_RUN;
                end
            end
            default: next_st.mode = rieu_pkg::MODE_RESET;
        endcase

        // Leaving reset launches the reset sequence at vector zero
        if (!running && next_st.mode == rieu_pkg::MODE_RUN) begin
            next_st.take = 1'b1;
            next_st.mask_set = 1'b1;
            next_st.vec_num = rieu_pkg::VEC_RESET;
            next_st.vec_addr = '0;
        end

        // A low pin overrides every other activity
        if (!st.clr_s2) begin
            next_st.mode = rieu_pkg::MODE_RESET;
            next_st.src_ext = 1'b1;
            next_st.take = 1'b0;
            next_st.mask_set = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st <= ST_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign chip_in_reset = ~running;
    assign exc_take = st.take;
    assign mask_set = st.mask_set;
    assign vec_num = st.vec_num;
    assign vec_addr = st.vec_addr;
    assign reg_rdata = st.rdata;
endmodule // rieu_top
`default_nettype wire

/* File: sim/rieu_chk.sv */
// Port assertions for the reset and interrupt exception unit
`timescale 1ns/10ps
`default_nettype none
module rieu_chk #(
    parameter logic [rieu_pkg::CNT_W-1:0] WDT_PULSE = rieu_pkg::WDT_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Inputs watched
    input wire logic chip_clear_n,
    input wire logic wdt_overflow_event,
    input wire logic instr_end,
    input wire logic seq_end,
    input wire logic cc_and_instr,
    input wire logic cc_or_instr,
    input wire logic cc_xor_instr,
    input wire logic cc_load_instr,
    input wire logic cond_code_mask,
    // Outputs watched
    input wire logic chip_in_reset,
    input wire logic exc_take,
    input wire logic mask_set,
    input wire logic [5:0] vec_num,
    input wire logic [rieu_pkg::VADDR_W-1:0] vec_addr
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (srst);
    logic [rieu_pkg::CNT_W-1:0] run;
    logic [1:0] ev_d;
    logic wflag;
    logic cc_any;
    assign cc_any = cc_and_instr | cc_or_instr | cc_xor_instr | cc_load_instr;
    // Length of the reset stay; the flag tells a watchdog stay from a pin stay
    always_ff @(posedge clock) begin
        if (srst) begin
            run <= 10'h000;
            ev_d <= 2'h0;
            wflag <= 1'b0;
        end else begin
            run <= chip_in_reset ? run + 10'h001 : 10'h000;
            ev_d <= {ev_d[0], wdt_overflow_event};
            if ($rose(chip_in_reset)) begin
                wflag <= |{ev_d, wdt_overflow_event};
            end
        end
    end
    sequence s_boot;
        !chip_in_reset && exc_take && vec_num == 6'h00;
    endsequence
    a_reset_wins: assert property (chip_in_reset |-> !exc_take)
        else $error("take while in reset");
    a_at_boundary: assert property (exc_take && vec_num != 6'h00 |-> $past(instr_end | seq_end))
        else $error("take away from a boundary");
    a_pin_release: assert property ($rose(chip_clear_n) |-> ##3 s_boot)
        else $error("no start after pin release");
    a_wdt_length: assert property ($fell(chip_in_reset) && wflag |-> run == WDT_PULSE)
        else $error("watchdog reset length wrong");
    a_mask_on_take: assert property (exc_take |-> mask_set)
        else $error("take without mask set");
    a_boot_vector: assert property ($fell(chip_in_reset) |-> s_boot)
        else $error("reset left without vector zero");
    a_cc_blocks: assert property (exc_take && vec_num != 6'h00 |-> !$past(cc_any))
        else $error("take after condition code instruction");
    a_mask_refuses: assert property (exc_take && vec_num != 6'h00 && $past(cond_code_mask) |-> vec_num == 6'h03)
        else $error("masked source taken");
    a_vector_addr: assert property (exc_take |-> vec_addr == {9'h000, vec_num, 1'b0})
        else $error("vector address wrong");
    a_vector_range: assert property (exc_take |-> vec_num <= 6'h2C && !(vec_num inside {6'h01, 6'h02}))
        else $error("vector outside table");
endmodule // rieu_chk
bind rieu_top rieu_chk #(.WDT_PULSE(WDT_PULSE)) u_chk (
    .clock, .srst, .chip_clear_n, .wdt_overflow_event, .instr_end, .seq_end,
    .cc_and_instr, .cc_or_instr, .cc_xor_instr, .cc_load_instr, .cond_code_mask,
    .chip_in_reset, .exc_take, .mask_set, .vec_num, .vec_addr
);
`default_nettype wire

/* File: sim/rieu_cpu_model.sv */
// Behavioural CPU core facing the exception unit
`timescale 1ns/10ps
`default_nettype none
module rieu_cpu_model (
    // Clock, reset and unit outputs
    input wire logic clock,
    input wire logic srst,
    input wire logic chip_in_reset,
    input wire logic exc_take,
    input wire logic mask_set,
    // Bench control
    input wire logic unmask,
    input wire logic [2:0] cc_sel,
    // Boundaries and mask flag
    output logic instr_end,
    output logic seq_end,
    output logic cc_and_instr,
    output logic cc_or_instr,
    output logic cc_xor_instr,
    output logic cc_load_instr,
    output logic cond_code_mask
);
    logic [1:0] phase;
    logic in_seq;
    // Halted while in reset so no boundary can race the start vector
    always_ff @(posedge clock) begin
        if (srst || chip_in_reset) begin
            phase <= 2'h0;
            in_seq <= 1'b0;
            instr_end <= 1'b0;
            seq_end <= 1'b0;
            cond_code_mask <= 1'b1;
        end else begin
            phase <= phase + 2'h1;
            instr_end <= phase == 2'h3 && !in_seq;
            seq_end <= phase == 2'h3 && in_seq;
            in_seq <= exc_take | (in_seq & (phase != 2'h3));
            if (mask_set) begin
                cond_code_mask <= 1'b1;
            end else if (unmask) begin
                cond_code_mask <= 1'b0;
            end
        end
    end
    assign cc_and_instr = instr_end && cc_sel == 3'h1;
    assign cc_or_instr = instr_end && cc_sel == 3'h2;
    assign cc_xor_instr = instr_end && cc_sel == 3'h3;
    assign cc_load_instr = instr_end && cc_sel == 3'h4;
endmodule // rieu_cpu_model
`default_nettype wire

/* File: sim/rieu_top_tb.sv */
// Self-checking bench for the reset and interrupt exception unit
`timescale 1ns/10ps
`default_nettype none
module rieu_top_tb;
    localparam int WDT = 4;
    logic clock = 1'b0, srst = 1'b1, chip_clear_n = 1'b0, unmaskable_pin = 1'b1;
    logic [7:0] ext_line_requests = 8'hFF, reg_wdata = 8'h00, reg_rdata;
    logic [32:0] periph_req = 33'h000000000;
    logic wdt_overflow_event = 1'b0, unmask = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] cc_sel = 3'h0;
    logic [3:0] reg_addr = 4'h0;
    logic instr_end, seq_end, cc_and_instr, cc_or_instr, cc_xor_instr, cc_load_instr;
    logic cond_code_mask, chip_in_reset, exc_take, mask_set;
    logic [5:0] vec_num;
    logic [15:0] vec_addr;
    int errors = 0, cmp_count = 0, cycles = 0;
    rieu_top #(.WDT_PULSE(10'(WDT))) u_dut (
        .clock, .srst, .clk_en(1'b1), .chip_clear_n, .unmaskable_pin,
        .ext_line_requests, .periph_req, .wdt_overflow_event, .instr_end,
        .seq_end, .cc_and_instr, .cc_or_instr, .cc_xor_instr, .cc_load_instr,
        .cond_code_mask, .chip_in_reset, .exc_take, .mask_set, .vec_num,
        .vec_addr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
    );
    rieu_cpu_model u_cpu (
        .clock, .srst, .chip_in_reset, .exc_take, .mask_set, .unmask, .cc_sel,
        .instr_end, .seq_end, .cc_and_instr, .cc_or_instr, .cc_xor_instr,
        .cc_load_instr, .cond_code_mask
    );
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata === e, "read data");
    endtask
    // Waits a bounded time; a take that never comes fails the compare
    task automatic take(input logic [5:0] v);
        #1;
        for (int i = 0; i < 100 && exc_take !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk(exc_take === 1'b1 && vec_num === v && vec_addr === {9'h000, v, 1'b0}, "vector");
        @(posedge clock);
    endtask
    task automatic none(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
            chk(exc_take === 1'b0, "unexpected take");
        end
    endtask
    // One-cycle pulse: 0 unmask, 1 unmaskable pin low, 2 watchdog overflow
    task automatic pulse(input int which);
        @(posedge clock);
        case (which)
            0: unmask <= 1'b1;
            1: unmaskable_pin <= 1'b0;
            default: wdt_overflow_event <= 1'b1;
        endcase
        @(posedge clock);
        unmask <= 1'b0;
        unmaskable_pin <= 1'b1;
        wdt_overflow_event <= 1'b0;
    endtask
    task automatic t_boot;
        repeat (12) @(posedge clock);
        chip_clear_n <= 1'b1;
        take(6'h00);
        chk(cond_code_mask === 1'b1, "mask after reset");
        rd(rieu_pkg::REG_CTRL, 8'h00);
        rd(rieu_pkg::REG_SENSE, 8'h00);
        rd(rieu_pkg::REG_ENABLE, 8'h00);
        rd(4'hF, 8'h00);
        $display("boot done");
    endtask
    task automatic t_lines;
        wr(rieu_pkg::REG_SENSE, 8'hFF);
        wr(rieu_pkg::REG_ENABLE, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            ext_line_requests <= ~(8'h01 << i);
            pulse(0);
            take(6'h04 + 6'(i));
            ext_line_requests <= 8'hFF;
        end
        @(posedge clock);
        ext_line_requests <= 8'hDB;
        periph_req <= 33'h000000001;
        none(12);
        rd(rieu_pkg::REG_PEND, 8'h24);
        pulse(0);
        take(6'h06);
        pulse(0);
        take(6'h09);
        pulse(0);
        take(6'h0C);
        periph_req <= 33'h000000000;
        ext_line_requests <= 8'hFF;
        $display("lines done");
    endtask
    task automatic t_level;
        wr(rieu_pkg::REG_SENSE, 8'h00);
        wr(rieu_pkg::REG_ENABLE, 8'h08);
        @(posedge clock);
        ext_line_requests <= 8'hF5;
        for (int k = 1; k < 5; k++) begin
            @(posedge clock);
            cc_sel <= 3'(k);
            pulse(0);
            none(16);
            cc_sel <= 3'h0;
            take(6'h07);
        end
        ext_line_requests <= 8'hFF;
        $display("level done");
    endtask
    task automatic t_nmi;
        pulse(1);
        take(6'h03);
        none(12);
        wr(rieu_pkg::REG_CTRL, 8'h01);
        @(posedge clock);
        unmaskable_pin <= 1'b0;
        none(12);
        unmaskable_pin <= 1'b1;
        take(6'h03);
        wr(rieu_pkg::REG_CTRL, 8'h00);
        $display("nmi done");
    endtask
    task automatic t_wdt;
        int n;
        n = 0;
        wr(rieu_pkg::REG_ENABLE, 8'h08);
        wr(rieu_pkg::REG_CTRL, 8'h04);
        pulse(2);
        // Count from the cycle the event lands, so the first reset cycle is seen
        #1;
        for (int i = 0; i < 40 && !(n > 0 && chip_in_reset === 1'b0); i++) begin
            if (chip_in_reset === 1'b1) n++;
            @(posedge clock);
            #1;
        end
        chk(n == WDT && exc_take === 1'b1 && vec_num === 6'h00, "watchdog reset");
        rd(rieu_pkg::REG_ENABLE, 8'h00);
        rd(rieu_pkg::REG_STATUS, 8'h02);
        wr(rieu_pkg::REG_CTRL, 8'h02);
        pulse(2);
        take(6'h03);
        wr(rieu_pkg::REG_CTRL, 8'h00);
        pulse(0);
        pulse(2);
        take(6'h2C);
        // Pin reset in mid-run
        @(posedge clock);
        chip_clear_n <= 1'b0;
        repeat (12) @(posedge clock);
        #1;
        chk(chip_in_reset === 1'b1 && exc_take === 1'b0, "pin reset");
        chip_clear_n <= 1'b1;
        take(6'h00);
        rd(rieu_pkg::REG_STATUS, 8'h03);
        $display("watchdog done");
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        forever #25 clock = ~clock;
    end
    // Whole run needs about 350 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            wrap_up;
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        t_boot;
        t_lines;
        t_level;
        t_nmi;
        t_wdt;
        wrap_up;
    end
endmodule // rieu_top_tb
`default_nettype wire
